// >>> design/pxs_consts.svh
// Purpose: Offsets, field positions, select codes and timing counts.
// Assumes: One aligned 32-bit word per register, byte address = 4 * index.
// Notes:   Indices are compared against paddr[11:2].
`ifndef PXS_CONSTS_SVH
`define PXS_CONSTS_SVH
`define PXS_LANES        1
`define PXS_IDX_W        10
`define PXS_IDX_FLAG_SEL 10'h314
`define PXS_IDX_FLAGS    10'h315
`define PXS_IDX_CDR      10'h321
`define PXS_IDX_PHY_CLOCK_STATUS  10'h322
`define PXS_IDX_FRAMING_ERROR_STICKY  10'h323
`define PXS_IDX_FRM_CLR  10'h324
`define PXS_IDX_PURGE    10'h325
`define PXS_IDX_ALIGN    10'h326
`define PXS_IDX_DESKEW   10'h329
`define PXS_IDX_IRQ_STAT 10'h330
`define PXS_IDX_IRQ_MASK 10'h331
`define PXS_IDX_RX_CLOCK_FREQ_METER   10'h341
`define PXS_IDX_TX_CLOCK_FREQ_METER   10'h342
`define PXS_IDX_ADAPT    10'h343
`define PXS_SEL_TX_FULL  3'h0
`define PXS_SEL_TX_EMPTY 3'h1
`define PXS_SEL_TX_PFULL 3'h2
`define PXS_SEL_TX_PEMPT 3'h3
`define PXS_SEL_RX_FULL  3'h4
`define PXS_SEL_RX_EMPTY 3'h5
`define PXS_SEL_RX_PFULL 3'h6
`define PXS_SEL_RX_PEMPT 3'h7
`define PXS_IRQ_FRM      0
`define PXS_IRQ_DESKEW   1
`define PXS_IRQ_BER      2
`define PXS_IRQ_W        3
`define PXS_BER_LIMIT    5'h10
`define PXS_BER_WIN_NS   50000
`define PXS_CLK_MHZ      200
`define PXS_FREQ_WIN     4'ha
`endif

// >>> design/pxs_pkg.sv
// Purpose: Types shared by the PHY status register bank.
// Assumes: pxs_consts.svh supplies lane count and widths.
// Notes:   Packed struct order puts the last field in bit 0.
`include "pxs_consts.svh"
package pxs_pkg;
   typedef struct packed {
      logic [`PXS_LANES-1:0] rx_pempty;
      logic [`PXS_LANES-1:0] rx_pfull;
      logic [`PXS_LANES-1:0] rx_empty;
      logic [`PXS_LANES-1:0] rx_full;
      logic [`PXS_LANES-1:0] tx_pempty;
      logic [`PXS_LANES-1:0] tx_pfull;
      logic [`PXS_LANES-1:0] tx_empty;
      logic [`PXS_LANES-1:0] tx_full;
   } pxs_fifo_flags_t;
   typedef struct packed {
      logic rx_cdr_locked;
      logic tx_mac_pll_locked;
      logic tx_pcs_ready;
   } pxs_clk_status_t;
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } pxs_apb_req_t;
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } pxs_apb_rsp_t;
   typedef struct packed {
      logic [3:0]  win;
      logic [31:0] cnt;
      logic [31:0] result;
      logic        prev;
   } pxs_meter_st_t;
   typedef struct packed {
      logic [31:0] win;
      logic [4:0]  cnt;
      logic        high;
   } pxs_ber_st_t;
   typedef struct packed {
      logic [2:0]            flag_sel;
      logic                  frm_clr;
      logic                  adapt_hold;
      logic                  framing_error_sticky;
      logic                  desk_prev;
      logic                  desk_chg;
      logic                  ber_prev;
      logic [`PXS_IRQ_W-1:0] irq_stat;
      logic [`PXS_IRQ_W-1:0] irq_mask;
      logic [31:0]           rdata;
      logic                  slverr;
   } pxs_bank_st_t;
endpackage

// >>> design/pxs_freq_meter.sv
// Purpose: Counts rising edges of a sampled MAC clock over a fixed window.
// Assumes: The MAC clock level is sampled synchronously to sys_clk.
// Notes:   Window is PXS_FREQ_WIN cycles, so f_mac = count * f_sys / 10.
`timescale 1ns/10ps
`include "pxs_consts.svh"
module pxs_freq_meter (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic        mac_level,
   output      logic [31:0] count
);
   import pxs_pkg::*;
   pxs_meter_st_t s;
   pxs_meter_st_t next_s;
   logic          rise;

   // Sampling limits the measurable MAC rate to half of sys_clk.
   always_comb begin
      next_s = s;
      rise = mac_level & ~s.prev;
      next_s.prev = mac_level;
      if (s.win == `PXS_FREQ_WIN - 4'h1) begin
         next_s.result = s.cnt + 32'(rise);
         next_s.cnt = 32'h0;
         next_s.win = 4'h0;
      end else begin
         next_s.cnt = s.cnt + 32'(rise);
         next_s.win = s.win + 4'h1;
      end
   end

   // Only the register reset clears the meter.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign count = s.result;
endmodule

// >>> design/pxs_ber_monitor.sv
// Purpose: Flags a high bit error rate from bit error pulses.
// Assumes: err_pulse is high one cycle per counted bit error.
// Notes:   The flag sets on the sixteenth error of a window and is
//          re-evaluated at each window end.
`timescale 1ns/10ps
`include "pxs_consts.svh"
module pxs_ber_monitor #(
   parameter int unsigned WIN_CYC = 10000
) (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic err_pulse,
   output      logic ber_high
);
   import pxs_pkg::*;
   pxs_ber_st_t s;
   pxs_ber_st_t next_s;
   logic        full;

   // The count saturates so a burst cannot wrap back below the limit.
   always_comb begin
      next_s = s;
      full = (s.cnt == `PXS_BER_LIMIT);
      if (err_pulse && !full) begin
         next_s.cnt = s.cnt + 5'h1;
      end
      if (err_pulse && s.cnt == `PXS_BER_LIMIT - 5'h1) begin
         next_s.high = 1'b1;
      end
      if (s.win == 32'(WIN_CYC - 1)) begin
         next_s.win = 32'h0;
         next_s.cnt = 5'h0;
         // A sixteenth error in the last cycle must still count.
         next_s.high = full | (err_pulse & (s.cnt == `PXS_BER_LIMIT - 5'h1));
      end else begin
         next_s.win = s.win + 32'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign ber_high = s.high;
endmodule

// >>> design/pxs_bank.sv
// Purpose: PHY status and control register bank behind an APB slave.
// Assumes: All status inputs are synchronous to sys_clk.
// Notes:   Read data is captured in the setup cycle; pready rises in the
//          first access cycle, so every transfer takes two cycles.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
`include "pxs_consts.svh"
module pxs_bank #(
   parameter int unsigned BER_WIN_CYC =
      `PXS_BER_WIN_NS * `PXS_CLK_MHZ / 1000
) (
   input  wire logic                  sys_clk,
   input  wire logic                  sys_rst,
   input  wire pxs_pkg::pxs_apb_req_t apb_req,
   output      pxs_pkg::pxs_apb_rsp_t apb_rsp,
   input  wire pxs_pkg::pxs_fifo_flags_t fifo_flags,
   input  wire logic [`PXS_LANES-1:0] cdr_lock,
   input  wire pxs_pkg::pxs_clk_status_t clk_status,
   input  wire logic                  word_lock,
   input  wire logic                  frame_err,
   input  wire logic                  rx_aligned,
   input  wire logic                  bit_err,
   input  wire logic                  all_deskewed,
   input  wire logic                  rx_mac_level,
   input  wire logic                  tx_mac_level,
   input  wire logic                  auto_adapt_en,
   output      logic                  adapt_idle,
   output      logic                  irq
);
   import pxs_pkg::*;

   pxs_bank_st_t          s;
   pxs_bank_st_t          next_s;
   logic                  setup;
   logic                  access;
   logic                  wr;
   logic [`PXS_IDX_W-1:0] idx;
   logic [`PXS_LANES-1:0] view;
   logic                  ber_high;
   logic [31:0]           rx_clock_freq_meter;
   logic [31:0]           tx_clock_freq_meter;
   logic [`PXS_IRQ_W-1:0] ev;

   // Picks one FIFO flag per lane; shared by the read path and checks.
   function automatic logic [`PXS_LANES-1:0] fifo_flag(
      input logic [2:0]      sel,
      input pxs_fifo_flags_t f
   );
      case (sel)
         `PXS_SEL_TX_FULL:  fifo_flag = f.tx_full;
         `PXS_SEL_TX_EMPTY: fifo_flag = f.tx_empty;
         `PXS_SEL_TX_PFULL: fifo_flag = f.tx_pfull;
         `PXS_SEL_TX_PEMPT: fifo_flag = f.tx_pempty;
         `PXS_SEL_RX_FULL:  fifo_flag = f.rx_full;
         `PXS_SEL_RX_EMPTY: fifo_flag = f.rx_empty;
         `PXS_SEL_RX_PFULL: fifo_flag = f.rx_pfull;
         `PXS_SEL_RX_PEMPT: fifo_flag = f.rx_pempty;
         default:           fifo_flag = '0;
      endcase
   endfunction

   // True for every index that answers without an error.
   function automatic logic mapped(input logic [`PXS_IDX_W-1:0] i);
      case (i)
         `PXS_IDX_FLAG_SEL, `PXS_IDX_FLAGS, `PXS_IDX_CDR,
         `PXS_IDX_PHY_CLOCK_STATUS, `PXS_IDX_FRAMING_ERROR_STICKY, `PXS_IDX_FRM_CLR,
         `PXS_IDX_PURGE, `PXS_IDX_ALIGN, `PXS_IDX_DESKEW,
         `PXS_IDX_IRQ_STAT, `PXS_IDX_IRQ_MASK, `PXS_IDX_RX_CLOCK_FREQ_METER,
         `PXS_IDX_TX_CLOCK_FREQ_METER, `PXS_IDX_ADAPT: mapped = 1'b1;
         default:                         mapped = 1'b0;
      endcase
   endfunction

   // Two meters share one module; each counts over its own window.
   pxs_freq_meter u_rx_meter (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .mac_level (rx_mac_level),
      .count     (rx_clock_freq_meter)
   );

   pxs_freq_meter u_tx_meter (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .mac_level (tx_mac_level),
      .count     (tx_clock_freq_meter)
   );

   pxs_ber_monitor #(
      .WIN_CYC (BER_WIN_CYC)
   ) u_ber (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .err_pulse (bit_err),
      .ber_high  (ber_high)
   );

   // Bus phase decode.
   assign setup  = apb_req.psel & ~apb_req.penable;
   assign access = apb_req.psel & apb_req.penable;
   assign wr     = access & apb_req.pwrite;
   assign idx    = apb_req.paddr[11:2];
   assign view   = fifo_flag(s.flag_sel, fifo_flags);

   // Events that feed the interrupt status, one bit each.
   always_comb begin
      ev = '0;
      ev[`PXS_IRQ_FRM] = frame_err & word_lock & ~s.frm_clr;
      ev[`PXS_IRQ_DESKEW] = (all_deskewed != s.desk_prev) & ~s.frm_clr;
      ev[`PXS_IRQ_BER] = ber_high & ~s.ber_prev;
   end

   // Next state: bus writes, sticky flags and read data capture.
   always_comb begin
      next_s = s;
      next_s.desk_prev = all_deskewed;
      next_s.ber_prev = ber_high;
      // Read data is sampled at setup so prdata comes from a flop.
      if (setup) begin
         next_s.slverr = ~mapped(idx);
         case (idx)
            `PXS_IDX_FLAG_SEL: next_s.rdata = 32'(s.flag_sel);
            `PXS_IDX_FLAGS:    next_s.rdata = 32'(view);
            `PXS_IDX_CDR:      next_s.rdata = 32'(cdr_lock);
            `PXS_IDX_PHY_CLOCK_STATUS:  next_s.rdata = 32'(clk_status);
            `PXS_IDX_FRAMING_ERROR_STICKY:  next_s.rdata = 32'(s.framing_error_sticky);
            `PXS_IDX_FRM_CLR:  next_s.rdata = 32'(s.frm_clr);
            `PXS_IDX_ALIGN:
               next_s.rdata = 32'({ber_high, rx_aligned});
            `PXS_IDX_DESKEW:
               next_s.rdata = 32'({s.desk_chg, all_deskewed});
            `PXS_IDX_IRQ_STAT: next_s.rdata = 32'(s.irq_stat);
            `PXS_IDX_IRQ_MASK: next_s.rdata = 32'(s.irq_mask);
            `PXS_IDX_RX_CLOCK_FREQ_METER:   next_s.rdata = rx_clock_freq_meter;
            `PXS_IDX_TX_CLOCK_FREQ_METER:   next_s.rdata = tx_clock_freq_meter;
            `PXS_IDX_ADAPT:    next_s.rdata = 32'(s.adapt_hold);
            default:           next_s.rdata = 32'h0;
         endcase
      end
      // Writes land in the access cycle; read-only words ignore them.
      if (wr) begin
         case (idx)
            `PXS_IDX_FLAG_SEL: next_s.flag_sel = apb_req.pwdata[2:0];
            `PXS_IDX_FRM_CLR:  next_s.frm_clr = apb_req.pwdata[0];
            `PXS_IDX_IRQ_MASK:
               next_s.irq_mask = apb_req.pwdata[`PXS_IRQ_W-1:0];
            `PXS_IDX_ADAPT:    next_s.adapt_hold = apb_req.pwdata[0];
            default:           next_s.adapt_hold = s.adapt_hold;
         endcase
      end
      // The clear bit is a level, so errors stay clear while it is set.
      if (s.frm_clr || !word_lock) begin
         next_s.framing_error_sticky = 1'b0;
      end else if (frame_err) begin
         next_s.framing_error_sticky = 1'b1;
      end
      // Any edge of the deskew level latches the change bit unless frm_clr is set.
      if (s.frm_clr) begin
         next_s.desk_chg = 1'b0;
      end else if (all_deskewed != s.desk_prev) begin
         next_s.desk_chg = 1'b1;
      end
      // Reading the status word clears it, but a new event still lands.
      if (access && !apb_req.pwrite && idx == `PXS_IDX_IRQ_STAT) begin
         next_s.irq_stat = ev;
      end else begin
         next_s.irq_stat = s.irq_stat | ev;
      end
   end

   // Only sys_rst touches this state; path resets never reach it.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Zero wait states: the access cycle always completes.
   assign apb_rsp.pready  = access;
   assign apb_rsp.pslverr = access & s.slverr;
   assign apb_rsp.prdata  = s.rdata;
   assign adapt_idle      = s.adapt_hold & auto_adapt_en;
   assign irq             = |(s.irq_stat & s.irq_mask);

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   rx_empty_sel_a: assert property (
      s.flag_sel == `PXS_SEL_RX_EMPTY |-> view == fifo_flags.rx_empty)
      else $error("Lane view does not show RX empty.");

   tx_full_sel_a: assert property (
      s.flag_sel == `PXS_SEL_TX_FULL |-> view == fifo_flags.tx_full)
      else $error("Lane view does not show TX full.");

   flag_read_a: assert property (
      setup && !apb_req.pwrite && idx == `PXS_IDX_FLAGS |=>
      apb_rsp.prdata == 32'(fifo_flag($past(s.flag_sel),
                                      $past(fifo_flags))))
      else $error("Lane flag read returned wrong data.");

   clk_read_a: assert property (
      setup && idx == `PXS_IDX_PHY_CLOCK_STATUS |=>
      apb_rsp.prdata == 32'($past(clk_status)))
      else $error("Clock status read returned wrong data.");

   frm_set_a: assert property (
      frame_err && word_lock && !s.frm_clr |=> s.framing_error_sticky)
      else $error("Frame error was not recorded.");

   frm_lock_a: assert property (
      !word_lock |=> !s.framing_error_sticky)
      else $error("Frame error survived loss of word lock.");

   frm_clear_a: assert property (
      s.frm_clr && frame_err |=> !s.framing_error_sticky && !s.desk_chg)
      else $error("Held clear did not keep sticky bits clear.");

   desk_latch_a: assert property (
      all_deskewed != s.desk_prev && !s.frm_clr |=>
      s.desk_chg [*2] or (s.desk_chg ##1 s.frm_clr))
      else $error("Deskew change bit did not latch.");

   adapt_hold_a: assert property (
      wr && idx == `PXS_IDX_ADAPT && apb_req.pwdata[0] && auto_adapt_en
      |=> adapt_idle || !auto_adapt_en)
      else $error("Adaptation hold did not take effect.");
endmodule

// >>> tb/pxs_bank_bench.sv
// Purpose: Self-checking bench for the PHY status register bank.
// Assumes: Zero-wait APB slave; BER window shortened to 100 cycles.
// Notes:   MAC levels toggle with periods of 5 and 10 clock cycles.
`timescale 1ns/10ps
`include "pxs_consts.svh"
module pxs_bank_bench;
   import pxs_pkg::*;
   logic                  sys_clk = 1'b0;
   logic                  sys_rst = 1'b1;
   pxs_apb_req_t          req = '0;
   pxs_apb_rsp_t          rsp;
   pxs_fifo_flags_t       flags;
   logic [`PXS_LANES-1:0] cdr;
   pxs_clk_status_t       clks;
   logic                  wlock, ferr, algn, berr, desk, rxl, txl, aen;
   logic                  adapt_idle, irq, err;
   logic [31:0]           rd;
   int                    n_fail = 0;
   int                    checks_done = 0;
   int                    cyc = 0;
   int                    mcnt = 0;

   pxs_bank #(.BER_WIN_CYC(100)) uut (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp),
      .fifo_flags(flags), .cdr_lock(cdr), .clk_status(clks),
      .word_lock(wlock), .frame_err(ferr), .rx_aligned(algn),
      .bit_err(berr), .all_deskewed(desk), .rx_mac_level(rxl),
      .tx_mac_level(txl), .auto_adapt_en(aen), .adapt_idle(adapt_idle),
      .irq(irq));

   // The 200 MHz system clock.
   always #2.5 sys_clk = ~sys_clk;

   // Fixed periods give exact edge counts whatever the window phase.
   always @(posedge sys_clk) begin
      mcnt <= (mcnt == 9) ? 0 : mcnt + 1;
      rxl <= (mcnt % 5) < 2;
      txl <= mcnt < 5;
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail = n_fail + 1;
         results();
      end
   end

   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // One APB transfer; an idle edge follows so strobes never re-rise at once.
   task automatic xfer(input logic wr, input logic [9:0] idx,
                       input logic [31:0] wd);
      req <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:{idx, 2'b00},
               pwdata:wd};
      @(posedge sys_clk);
      req.penable <= 1'b1;
      @(posedge sys_clk);
      // Only the bench timeout ends a wait for pready.
      while (rsp.pready !== 1'b1) begin
         @(posedge sys_clk);
      end
      rd = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
      @(posedge sys_clk);
   endtask

   task automatic wr(input logic [9:0] idx, input logic [31:0] d);
      xfer(1'b1, idx, d);
   endtask

   task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
      xfer(1'b0, idx, 32'h0);
      chk(rd, exp);
   endtask

   // A frame error pulse, then time for the sticky bit to settle.
   task automatic pulse_frm();
      ferr <= 1'b1;
      tick(1);
      ferr <= 1'b0;
      tick(2);
   endtask

   task automatic t_reset();
      rdc(`PXS_IDX_RX_CLOCK_FREQ_METER, 32'h0);
      rdc(`PXS_IDX_FRM_CLR, 32'h0);
      rdc(`PXS_IDX_PURGE, 32'h0);
      $display("test reset done");
   endtask

   task automatic t_flags();
      for (int s = 0; s < 8; s++) begin
         wr(`PXS_IDX_FLAG_SEL, 32'(s));
         flags <= pxs_fifo_flags_t'(8'h01 << s);
         tick(2);
         rdc(`PXS_IDX_FLAGS, 32'h1);
         flags <= pxs_fifo_flags_t'(~(8'h01 << s));
         tick(2);
         rdc(`PXS_IDX_FLAGS, 32'h0);
      end
      $display("test flags done");
   endtask

   task automatic t_status();
      for (int v = 0; v < 8; v++) begin
         clks <= pxs_clk_status_t'(v[2:0]);
         cdr <= v[0];
         algn <= v[1];
         tick(2);
         rdc(`PXS_IDX_PHY_CLOCK_STATUS, 32'(v[2:0]));
         rdc(`PXS_IDX_CDR, 32'(v[0]));
         rdc(`PXS_IDX_ALIGN, 32'(v[1]));
      end
      wr(`PXS_IDX_PHY_CLOCK_STATUS, 32'h0);
      rdc(`PXS_IDX_PHY_CLOCK_STATUS, 32'h7);
      xfer(1'b0, 10'h000, 32'h0);
      chk(32'(err), 32'h1);
      chk(rd, 32'h0);
      $display("test status done");
   endtask

   task automatic t_frame();
      pulse_frm();
      rdc(`PXS_IDX_FRAMING_ERROR_STICKY, 32'h1);
      tick(5);
      rdc(`PXS_IDX_FRAMING_ERROR_STICKY, 32'h1);
      wlock <= 1'b0;
      tick(2);
      rdc(`PXS_IDX_FRAMING_ERROR_STICKY, 32'h0);
      wlock <= 1'b1;
      pulse_frm();
      wr(`PXS_IDX_FRM_CLR, 32'h1);
      rdc(`PXS_IDX_FRAMING_ERROR_STICKY, 32'h0);
      rdc(`PXS_IDX_FRM_CLR, 32'h1);
      pulse_frm();
      rdc(`PXS_IDX_FRAMING_ERROR_STICKY, 32'h0);
      wr(`PXS_IDX_FRM_CLR, 32'h0);
      pulse_frm();
      rdc(`PXS_IDX_FRAMING_ERROR_STICKY, 32'h1);
      $display("test frame done");
   endtask

   task automatic t_desk();
      desk <= 1'b1;
      tick(2);
      rdc(`PXS_IDX_DESKEW, 32'h3);
      rdc(`PXS_IDX_IRQ_STAT, 32'h3);
      tick(4);
      rdc(`PXS_IDX_DESKEW, 32'h3);
      wr(`PXS_IDX_FRM_CLR, 32'h1);
      rdc(`PXS_IDX_DESKEW, 32'h1);
      rdc(`PXS_IDX_FRAMING_ERROR_STICKY, 32'h0);
      wr(`PXS_IDX_FRM_CLR, 32'h0);
      rdc(`PXS_IDX_DESKEW, 32'h1);
      desk <= 1'b0;
      tick(2);
      rdc(`PXS_IDX_DESKEW, 32'h2);
      $display("test deskew done");
   endtask

   // Thirty-two errors in a row put sixteen in one window at any phase.
   task automatic t_ber();
      berr <= 1'b1;
      tick(15);
      berr <= 1'b0;
      tick(2);
      rdc(`PXS_IDX_ALIGN, 32'h1);
      tick(250);
      berr <= 1'b1;
      tick(32);
      berr <= 1'b0;
      tick(2);
      rdc(`PXS_IDX_ALIGN, 32'h3);
      rdc(`PXS_IDX_IRQ_STAT, 32'h6);
      tick(250);
      rdc(`PXS_IDX_ALIGN, 32'h1);
      $display("test error rate done");
   endtask

   task automatic t_irq();
      wr(`PXS_IDX_IRQ_MASK, 32'h0);
      xfer(1'b0, `PXS_IDX_IRQ_STAT, 32'h0);
      pulse_frm();
      chk(32'(irq), 32'h0);
      rdc(`PXS_IDX_IRQ_STAT, 32'h1);
      rdc(`PXS_IDX_IRQ_STAT, 32'h0);
      wr(`PXS_IDX_IRQ_MASK, 32'h7);
      rdc(`PXS_IDX_IRQ_MASK, 32'h7);
      wr(`PXS_IDX_FRM_CLR, 32'h1);
      wr(`PXS_IDX_FRM_CLR, 32'h0);
      pulse_frm();
      chk(32'(irq), 32'h1);
      xfer(1'b0, `PXS_IDX_IRQ_STAT, 32'h0);
      tick(1);
      chk(32'(irq), 32'h0);
      $display("test interrupt done");
   endtask

   task automatic t_misc();
      rdc(`PXS_IDX_RX_CLOCK_FREQ_METER, 32'h2);
      rdc(`PXS_IDX_TX_CLOCK_FREQ_METER, 32'h1);
      aen <= 1'b1;
      wr(`PXS_IDX_ADAPT, 32'h1);
      chk(32'(adapt_idle), 32'h1);
      rdc(`PXS_IDX_ADAPT, 32'h1);
      aen <= 1'b0;
      tick(1);
      chk(32'(adapt_idle), 32'h0);
      aen <= 1'b1;
      wr(`PXS_IDX_ADAPT, 32'h0);
      chk(32'(adapt_idle), 32'h0);
      $display("test meter and adaptation done");
   endtask

   // Main sequence: reset for twelve cycles, then each scenario in turn.
   initial begin
      flags = '0;
      cdr = '0;
      clks = '0;
      {wlock, ferr, algn, berr, desk, rxl, txl, aen} = 8'h00;
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      wlock <= 1'b1;
      t_reset();
      t_flags();
      t_status();
      t_frame();
      t_desk();
      t_ber();
      t_irq();
      t_misc();
      results();
   end
endmodule
